// ---- hdl/cscr_pkg.sv ----
// cscr_pkg: offsets, field positions, reset values and encodings for the
// core system control register bank.
// assumes: an 8-bit io register space on the system clock.
package cscr_pkg;

   // register offsets in the io space
   localparam logic [7:0] OFF_ALU_FLAGS = 8'h00;
   localparam logic [7:0] OFF_STACK_PTR = 8'h02;
   localparam logic [7:0] OFF_CLOCK_MODE = 8'h03;
   localparam logic [7:0] OFF_INT_ENABLE = 8'h04;
   localparam logic [7:0] OFF_INT_REQUEST = 8'h05;
   localparam logic [7:0] OFF_TIMER_MODE = 8'h06;
   localparam logic [7:0] OFF_EDGE_SELECT = 8'h0C;

   // alu flag positions
   localparam int FLAG_ZERO = 0;
   localparam int FLAG_CARRY = 1;
   localparam int FLAG_AUX = 2;
   localparam int FLAG_OVF = 3;
   localparam logic [7:0] FLAG_MASK = 8'h0F;

   // clock mode fields
   localparam int CM_PIN_FN = 0;
   localparam int CM_WDOG = 1;
   localparam int CM_SLOW_EN = 2;
   localparam int CM_TYPE = 3;
   localparam int CM_FAST_EN = 4;
   localparam int CM_SEL_LO = 5;
   localparam logic [7:0] CLOCK_MODE_RESET = 8'hF6;

   // interrupt bit positions, shared by enable and request
   localparam int IRQ_PAIR_A = 0;
   localparam int IRQ_PAIR_B = 1;
   localparam int IRQ_T16 = 2;
   localparam int IRQ_ADC = 3;
   localparam int IRQ_CMP = 4;
   localparam int IRQ_T2 = 6;
   localparam int IRQ_T3 = 7;
   localparam logic [7:0] IRQ_MASK = 8'hDF;

   // timer mode fields
   localparam int TM_BITSEL_LO = 0;
   localparam int TM_DIV_LO = 3;
   localparam int TM_SRC_LO = 5;
   localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
   localparam int EDGE_T16_BIT = 4;
   localparam logic [7:0] EDGE_MASK = 8'h10;
   localparam int WATCH_BIT_BASE = 8;

   // system clock source selection
   typedef enum logic [3:0] {
      CSCR_CLK_FAST_DIV4, CSCR_CLK_FAST_DIV2, CSCR_CLK_XTAL_DIV4,
      CSCR_CLK_XTAL_DIV2, CSCR_CLK_XTAL, CSCR_CLK_SLOW_DIV4, CSCR_CLK_SLOW,
      CSCR_CLK_FAST_DIV16, CSCR_CLK_FAST_DIV8, CSCR_CLK_SLOW_DIV16,
      CSCR_CLK_FAST_DIV32, CSCR_CLK_FAST_DIV64, CSCR_CLK_XTAL_DIV8,
      CSCR_CLK_RESERVED
   } cscr_clk_sel_e;

   // timer clock source selection
   typedef enum logic [2:0] {
      CSCR_TSRC_OFF, CSCR_TSRC_SYS, CSCR_TSRC_RSVD, CSCR_TSRC_PIN_A,
      CSCR_TSRC_FAST, CSCR_TSRC_XTAL, CSCR_TSRC_SLOW, CSCR_TSRC_PIN_B
   } cscr_tsrc_e;

   // alu result carried from the core
   typedef struct packed {
      logic upd_zero;
      logic upd_carry;
      logic upd_aux;
      logic upd_ovf;
      logic zero;
      logic carry;
      logic aux;
      logic ovf;
   } cscr_alu_s;

   // decoded clock and timer control
   typedef struct packed {
      cscr_clk_sel_e sys_sel;
      logic fast_en;
      logic slow_en;
      logic wdog_en;
      logic pin_is_reset;
      cscr_tsrc_e tsrc;
      logic [1:0] tdiv;
      logic [2:0] tbit;
   } cscr_ctrl_s;

endpackage : cscr_pkg

// ---- hdl/cscr_bank.sv ----
// cscr_bank: core control register bank: alu flags, stack pointer, clock
// mode, interrupt enable and request, wide timer mode and edge select.
// assumes: core updates flags and stack pointer through strobes, sources
// give one-cycle event pulses on clk_i, timer count is on clk_i.
//
// Notes on behaviour
// RL1: overflow flag bit 3 set on signed overflow
// RL2: aux carry bit 2 on nibble carry/borrow
// RL3: carry bit 1 on carry, borrow, shifts
// RL4: zero flag bit 0 follows result zero
// RL5: stack pointer reads current, writes replace
// RL6: type 0 clock select decode, reset 111
// RL7: bit 3 selects type 1 clock decode
// RL8: bit 4 enables fast oscillator, reset one
// RL9: bit 2 slow oscillator, clearing kills watchdog
// RL10: bit 1 enables watchdog, reset one
// RL11: bit 0 picks port pin or reset
// RL12: interrupt enable gates each source, reset zero
// RL13: request bits set by source, software clears
// RL14: timer mode picks source and pre-divider
// RL15: selected timer bit 8..15 change raises interrupt
// RL16: edge select chooses rising or falling
// RL17: reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none

module cscr_bank
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic [7:0] addr_i, // io register address
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [7:0] rdata_o, // read data, cycle after rd_i
   input wire cscr_pkg::cscr_alu_s alu_i, // alu flag update
   input wire logic sp_load_i, // core stack pointer load
   input wire logic [7:0] sp_value_i, // core stack pointer value
   input wire logic [7:0] irq_src_i, // source event pulses
   input wire logic [15:0] timer_count_i, // wide timer count
   output logic [7:0] flags_o, // alu flags to the core
   output logic [7:0] stack_pointer_o, // stack pointer to the core
   output cscr_pkg::cscr_ctrl_s ctrl_o, // decoded clock/timer control
   output logic [7:0] pending_o, // enabled pending requests
   output logic irq_o // any enabled request pending
);

   logic [7:0] alu_status_flags;
   logic [7:0] stack_pointer;
   logic [7:0] clock_mode;
   logic [7:0] interrupt_enable;
   logic [7:0] interrupt_request;
   logic [7:0] wide_timer_mode;
   logic [7:0] edge_select;
   logic watch_prev;
   logic watch_now;
   logic timer_event;
   logic [7:0] next_request;
   cscr_pkg::cscr_clk_sel_e next_sys_sel;
   cscr_pkg::cscr_ctrl_s next_ctrl;
   logic [2:0] sel_code;

   ////////////////////////////////////////////////////////////////////////
   // alu flags: core update wins over a software write in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alu_status_flags <= 8'h00;
      end
      else
      begin
         if (wr_i && addr_i == cscr_pkg::OFF_ALU_FLAGS)
         begin
            alu_status_flags <= wdata_i & cscr_pkg::FLAG_MASK; // [RL17]
         end
         if (alu_i.upd_ovf)
         begin
            alu_status_flags[cscr_pkg::FLAG_OVF] <= alu_i.ovf; // [RL1]
         end
         if (alu_i.upd_aux)
         begin
            alu_status_flags[cscr_pkg::FLAG_AUX] <= alu_i.aux; // [RL2]
         end
         if (alu_i.upd_carry)
         begin
            alu_status_flags[cscr_pkg::FLAG_CARRY] <= alu_i.carry; // [RL3]
         end
         if (alu_i.upd_zero)
         begin
            alu_status_flags[cscr_pkg::FLAG_ZERO] <= alu_i.zero; // [RL4]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stack pointer: core push/pop load wins over a software write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stack_pointer <= 8'h00;
      end
      else if (sp_load_i)
      begin
         stack_pointer <= sp_value_i; // [RL5]
      end
      else if (wr_i && addr_i == cscr_pkg::OFF_STACK_PTR)
      begin
         stack_pointer <= wdata_i; // [RL5]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock mode register, defaults slow clock, both rc on, watchdog on
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clock_mode <= cscr_pkg::CLOCK_MODE_RESET; // [RL6] [RL8] [RL10]
      end
      else if (wr_i && addr_i == cscr_pkg::OFF_CLOCK_MODE)
      begin
         clock_mode <= wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enable, timer mode and edge select registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         interrupt_enable <= 8'h00; // [RL12]
         wide_timer_mode <= cscr_pkg::TIMER_MODE_RESET;
         edge_select <= 8'h00;
      end
      else if (wr_i)
      begin
         if (addr_i == cscr_pkg::OFF_INT_ENABLE)
         begin
            interrupt_enable <= wdata_i & cscr_pkg::IRQ_MASK; // [RL12] [RL17]
         end
         if (addr_i == cscr_pkg::OFF_TIMER_MODE)
         begin
            wide_timer_mode <= wdata_i; // [RL14]
         end
         if (addr_i == cscr_pkg::OFF_EDGE_SELECT)
         begin
            edge_select <= wdata_i & cscr_pkg::EDGE_MASK; // [RL17]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer bit watch: the selected count bit's edge makes an event
   assign watch_now = timer_count_i[cscr_pkg::WATCH_BIT_BASE +
      int'(wide_timer_mode[cscr_pkg::TM_BITSEL_LO +: 3])]; // [RL15]

   // reset follows the watched bit, so a count already high after reset
   // does not look like a fresh edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         watch_prev <= watch_now;
      end
      else
      begin
         watch_prev <= watch_now;
      end
   end

   // rising edge when select is 0, falling when 1
   assign timer_event = edge_select[cscr_pkg::EDGE_T16_BIT]
      ? (watch_prev && !watch_now) // [RL16]
      : (!watch_prev && watch_now); // [RL16]

   ////////////////////////////////////////////////////////////////////////
   // request bits: write one clears, a new event wins over the clear
   always_comb
   begin
      next_request = interrupt_request;
      if (wr_i && addr_i == cscr_pkg::OFF_INT_REQUEST)
      begin
         next_request = interrupt_request & ~wdata_i; // [RL13]
      end
      next_request = next_request | irq_src_i; // [RL13]
      next_request[cscr_pkg::IRQ_T16] = next_request[cscr_pkg::IRQ_T16]
         | timer_event; // [RL15]
      next_request = next_request & cscr_pkg::IRQ_MASK; // [RL17]
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         interrupt_request <= 8'h00;
      end
      else
      begin
         interrupt_request <= next_request;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock select decode for both clock types
   assign sel_code = clock_mode[cscr_pkg::CM_SEL_LO +: 3];

   always_comb
   begin
      next_sys_sel = cscr_pkg::CSCR_CLK_RESERVED;
      if (!clock_mode[cscr_pkg::CM_TYPE])
      begin
         case (sel_code) // [RL6]
            3'h0: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV4;
            3'h1: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV2;
            3'h3: next_sys_sel = cscr_pkg::CSCR_CLK_XTAL_DIV4;
            3'h4: next_sys_sel = cscr_pkg::CSCR_CLK_XTAL_DIV2;
            3'h5: next_sys_sel = cscr_pkg::CSCR_CLK_XTAL;
            3'h6: next_sys_sel = cscr_pkg::CSCR_CLK_SLOW_DIV4;
            3'h7: next_sys_sel = cscr_pkg::CSCR_CLK_SLOW;
            default: next_sys_sel = cscr_pkg::CSCR_CLK_RESERVED;
         endcase
      end
      else
      begin
         case (sel_code) // [RL7]
            3'h0: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV16;
            3'h1: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV8;
            3'h2: next_sys_sel = cscr_pkg::CSCR_CLK_SLOW_DIV16;
            3'h3: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV32;
            3'h4: next_sys_sel = cscr_pkg::CSCR_CLK_FAST_DIV64;
            3'h5: next_sys_sel = cscr_pkg::CSCR_CLK_XTAL_DIV8;
            default: next_sys_sel = cscr_pkg::CSCR_CLK_RESERVED;
         endcase
      end
   end

   // gather control outputs
   always_comb
   begin
      next_ctrl.sys_sel = next_sys_sel;
      next_ctrl.fast_en = clock_mode[cscr_pkg::CM_FAST_EN]; // [RL8]
      next_ctrl.slow_en = clock_mode[cscr_pkg::CM_SLOW_EN]; // [RL9]
      next_ctrl.wdog_en = clock_mode[cscr_pkg::CM_WDOG]
         && clock_mode[cscr_pkg::CM_SLOW_EN]; // [RL9] [RL10]
      next_ctrl.pin_is_reset = clock_mode[cscr_pkg::CM_PIN_FN]; // [RL11]
      next_ctrl.tsrc = cscr_pkg::cscr_tsrc_e'(
         wide_timer_mode[cscr_pkg::TM_SRC_LO +: 3]); // [RL14]
      next_ctrl.tdiv = wide_timer_mode[cscr_pkg::TM_DIV_LO +: 2]; // [RL14]
      next_ctrl.tbit = wide_timer_mode[cscr_pkg::TM_BITSEL_LO +: 3];
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs toward the core and clock logic
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_o <= '0;
         flags_o <= 8'h00;
         stack_pointer_o <= 8'h00;
         pending_o <= 8'h00;
         irq_o <= 1'b0;
      end
      else
      begin
         ctrl_o <= next_ctrl;
         flags_o <= alu_status_flags;
         stack_pointer_o <= stack_pointer;
         pending_o <= interrupt_request & interrupt_enable; // [RL12]
         irq_o <= |(interrupt_request & interrupt_enable); // [RL12]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after rd_i, unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (rd_i)
      begin
         case (addr_i)
            cscr_pkg::OFF_ALU_FLAGS: rdata_o <= alu_status_flags;
            cscr_pkg::OFF_STACK_PTR: rdata_o <= stack_pointer; // [RL5]
            cscr_pkg::OFF_CLOCK_MODE: rdata_o <= clock_mode;
            cscr_pkg::OFF_INT_ENABLE: rdata_o <= interrupt_enable;
            cscr_pkg::OFF_INT_REQUEST: rdata_o <= interrupt_request;
            cscr_pkg::OFF_TIMER_MODE: rdata_o <= wide_timer_mode;
            cscr_pkg::OFF_EDGE_SELECT: rdata_o <= edge_select;
            default: rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

endmodule : cscr_bank

`default_nettype wire

// ---- tb/cscr_timer_model.sv ----
// cscr_timer_model: wide timer count seen by the register bank.
// assumes: bench loads counts, one clock, sync high reset.
`timescale 1ns/1ps
`default_nettype none
module cscr_timer_model
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic load_i, // load strobe
   input wire logic [15:0] value_i, // count to load
   output logic [15:0] count_o // count
);
   // count only moves on a load, so each edge is placed on purpose
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         count_o <= 16'h0000;
      else if (load_i)
         count_o <= value_i;
   end
endmodule : cscr_timer_model
`default_nettype wire

// ---- tb/cscr_bank_asserts.sv ----
// cscr_bank_asserts: port checks of the control register bank.
// assumes: bound into cscr_bank, one clock, sync high reset.
`timescale 1ns/1ps
`default_nettype none
module cscr_bank_asserts
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic [7:0] addr_i, // address
   input wire logic wr_i, // write
   input wire logic rd_i, // read
   input wire logic [7:0] rdata_o, // read data
   input wire cscr_pkg::cscr_alu_s alu_i, // alu update
   input wire logic sp_load_i, // sp load
   input wire logic [7:0] sp_value_i, // sp value
   input wire logic [7:0] flags_o, // flags
   input wire logic [7:0] stack_pointer_o, // sp
   input wire cscr_pkg::cscr_ctrl_s ctrl_o, // control
   input wire logic [7:0] pending_o, // pending
   input wire logic irq_o // interrupt
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // bus, flag, clock, stack pointer and interrupt relations
   a_unmap_zero: assert property (rd_i && addr_i == 8'h07
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   a_flag_rsvd: assert property (flags_o[7:4] == 4'h0)
      else $error("reserved flag bits set");
   a_irq_level: assert property (irq_o == (pending_o != 8'h00))
      else $error("irq line disagrees with pending");
   a_wdog_gate: assert property (ctrl_o.wdog_en |-> ctrl_o.slow_en)
      else $error("watchdog on without slow osc");
   a_reset_clk: assert property ($fell(rst_i) |=>
      ctrl_o.sys_sel == cscr_pkg::CSCR_CLK_SLOW && ctrl_o.fast_en
      && ctrl_o.wdog_en && !ctrl_o.pin_is_reset)
      else $error("clock control not at reset state");
   a_sp_load: assert property (sp_load_i ##1 !(sp_load_i || wr_i)
      |=> stack_pointer_o == $past(sp_value_i, 2))
      else $error("stack pointer load lost");
   a_zero_upd: assert property (alu_i.upd_zero ##1
      !(wr_i || alu_i.upd_zero)
      |=> flags_o[0] == $past(alu_i.zero, 2))
      else $error("zero flag not updated");
   a_ovf_upd: assert property (alu_i.upd_ovf ##1
      !(wr_i || alu_i.upd_ovf)
      |=> flags_o[3] == $past(alu_i.ovf, 2))
      else $error("overflow flag not updated");
   a_pend_keep: assert property (pending_o[3] && !$past(wr_i)
      |=> pending_o[3]) else $error("pending request dropped");
   c_irq_rise: cover property ($rose(irq_o));
   c_timer_req: cover property (pending_o[2]);
   c_sp_load: cover property (sp_load_i && wr_i);
endmodule : cscr_bank_asserts
bind cscr_bank cscr_bank_asserts i_cscr_bank_asserts
(
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .alu_i(alu_i), .sp_load_i(sp_load_i),
   .sp_value_i(sp_value_i), .flags_o(flags_o),
   .stack_pointer_o(stack_pointer_o), .ctrl_o(ctrl_o),
   .pending_o(pending_o), .irq_o(irq_o)
);
`default_nettype wire

// ---- tb/tb.sv ----
// tb: random and corner tests of the control register bank.
// assumes: cscr_bank and cscr_timer_model, 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, irq_src = 8'h00;
   logic [7:0] sp_value = 8'h00, rdata, flags, sp_o, pending, v, r, e, got;
   logic wr = 1'h0, rd = 1'h0, sp_load = 1'h0, tload = 1'h0, irq;
   logic [15:0] tval = 16'h0000, tcount;
   logic [31:0] seed = 32'h0000000D;
   cscr_pkg::cscr_alu_s alu = '0;
   cscr_pkg::cscr_ctrl_s ctrl;
   int failures = 0, cmp_count = 0, cyc = 0;
   // clock select per {type, code}, in cscr_clk_sel_e order
   localparam logic [63:0] TAB = 64'hDDCBA98765432D10;
   localparam logic [7:0] OFFS [9] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h0C, 8'h01, 8'h07};
   localparam logic [7:0] RSTV [9] = '{8'h00, 8'h00, 8'hF6, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00};
   cscr_bank i_cscr_bank
   (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .alu_i(alu),
      .sp_load_i(sp_load), .sp_value_i(sp_value), .irq_src_i(irq_src),
      .timer_count_i(tcount), .flags_o(flags), .stack_pointer_o(sp_o),
      .ctrl_o(ctrl), .pending_o(pending), .irq_o(irq)
   );
   cscr_timer_model i_cscr_timer_model
   (
      .clk_i(clk_i), .rst_i(rst_i), .load_i(tload), .value_i(tval),
      .count_o(tcount)
   );
   ////////////////////////////////////////////////////////////////////////
   always #2.5 clk_i = ~clk_i;
   // hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         close_out();
      end
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // flags after an alu update: struct order is reversed to bit order
   function automatic logic [7:0] flag_next(logic [7:0] o, logic [7:0] a);
      logic [3:0] u;
      u = {a[4], a[5], a[6], a[7]};
      return {4'h0, (o[3:0] & ~u) | ({a[0], a[1], a[2], a[3]} & u)};
   endfunction : flag_next
   task automatic chk(input string n, input logic [7:0] x, logic [7:0] g);
      cmp_count++;
      if (g !== x)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk_i);
      wr <= 1'h0;
   endtask : put
   task automatic rchk(input string n, logic [7:0] a, logic [7:0] x);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk_i);
      rd <= 1'h0;
      #1 chk(n, x, rdata);
   endtask : rchk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   // load a count, then let the edge detector and request settle
   task automatic load(input logic [15:0] x);
      @(posedge clk_i);
      tval <= x;
      tload <= 1'h1;
      @(posedge clk_i);
      tload <= 1'h0;
      tick(3);
   endtask : load
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'h0;
      foreach (OFFS[i]) rchk("reset", OFFS[i], RSTV[i]);
      repeat (8)
      begin
         v = rnd();
         put(8'h02, v);
         rchk("sp", 8'h02, v);
         put(8'h04, v);
         rchk("ien", 8'h04, v & 8'hDF);
         put(8'h00, v);
         got = v & 8'h0F;
         rchk("flag", 8'h00, got);
         put(8'h06, v);
         tick(1);
         chk("tmode", v, ctrl[7:0]);
         put(8'h0C, v);
         rchk("edge", 8'h0C, v & 8'h10);
      end
      for (int k = 0; k < 16; k++)
      begin
         r = rnd();
         v = {k[2:0], r[4], k[3], r[2:0]};
         put(8'h03, v);
         tick(1);
         e = {TAB[4*k +: 4], v[4], v[2], v[1] & v[2], v[0]};
         chk("clk", e, ctrl[15:8]);
      end
      repeat (8)
      begin
         r = rnd() | 8'h90;
         @(posedge clk_i);
         alu <= r;
         @(posedge clk_i);
         alu <= '0;
         got = flag_next(got, r);
         rchk("flags", 8'h00, got);
         chk("flags_o", got, flags);
      end
      // core load and software write in the same cycle
      v = rnd();
      @(posedge clk_i);
      {sp_value, sp_load, addr, wdata, wr} <= {v, 1'h1, 8'h02, ~v, 1'h1};
      @(posedge clk_i);
      {sp_load, wr} <= 2'h0;
      tick(2);
      chk("sp_o", v, sp_o);
      // raise, mask and clear requests
      put(8'h04, 8'hFF);
      r = rnd() | 8'h09;
      @(posedge clk_i);
      irq_src <= r;
      @(posedge clk_i);
      irq_src <= 8'h00;
      rchk("irq", 8'h05, r & 8'hDF);
      chk("pend", r & 8'hDF, pending);
      chk("line", 8'h01, {7'h00, irq});
      put(8'h04, 8'h00);
      tick(2);
      chk("line", 8'h00, {7'h00, irq});
      put(8'h05, r);
      rchk("irq", 8'h05, 8'h00);
      // every watched timer bit, both edge polarities
      put(8'h04, 8'h04);
      for (int k = 0; k < 16; k++)
      begin
         put(8'h06, {5'h00, k[2:0]});
         put(8'h0C, {3'h0, k[3], 4'h0});
         put(8'h05, 8'h04);
         load((16'h0100 << k[2:0]) | {8'h00, rnd()});
         rchk("t_rise", 8'h05, {5'h00, ~k[3], 2'h0});
         put(8'h05, 8'h04);
         load(16'h0000);
         rchk("t_fall", 8'h05, {5'h00, k[3], 2'h0});
      end
      close_out();
   end
endmodule : tb
`default_nettype wire
